/* bench/pfsc_proc_model.sv */
// Processor-side partner: clock pulse source and halt line driver
`timescale 1ns/10ps
module pfsc_proc_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Commands from the bench
  input wire logic clk_fail,
  input wire logic halt_req,
  // Lines into the block
  output logic cpu_clk_pulse,
  output logic halt_line
);
  // ------------------------------------------------------------
  // Pulse source
  // ------------------------------------------------------------
  // Toggles every cycle; a failure freezes it so the watchdog sees no edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_clk_pulse <= 1'b0;
    end else if (!clk_fail) begin
      cpu_clk_pulse <= ~cpu_clk_pulse;
    end
  end
  // Coordinator raises halt to stop this processor
  assign halt_line = halt_req;
endmodule : pfsc_proc_model

/* bench/plc_fault_status_capture_tb.sv */
// Self-checking bench for the fault status capture block
`timescale 1ns/10ps
module plc_fault_status_capture_tb;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic pready, pslverr, perr, mrun, frun, preq, stop, hcall, odis, ureq, cpu_clk_pulse, halt_line;
  logic mload = 1'b1, fload = 1'b1, pload = 1'b0, halt_req = 1'b0, clk_fail = 1'b0;
  logic sysreq = 1'b0, bcall = 1'b0, ienter = 1'b0, pdone = 1'b0, mfail = 1'b0, rdone = 1'b0;
  logic [15:0] vb [4] = '{16'hE200, 16'hE280, 16'hE300, 16'hE400};
  pfsc_pkg::pfsc_mem_t mem = pfsc_pkg::PFSC_MEM_RAM32;
  pfsc_pkg::pfsc_ctx_t ctx = '0;
  pfsc_pkg::pfsc_evt_t evt = '0, e;
  int bad_count = 0, samples_checked = 0, n;

  // 200 MHz clock
  always #2.5 pclk = ~pclk;

  pfsc_proc_model model (.pclk, .presetn, .clk_fail, .halt_req, .cpu_clk_pulse, .halt_line);
  // Short period keeps the periodic scenario brief
  pfsc_fault_capture #(.PERIOD_CYCLES(50), .IRQ_DEPTH(8)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .main_cycle_block_loaded(mload), .fallback_cycle_block_loaded(fload), .periodic_block_loaded(pload),
    .mem_type(mem), .cpu_clk_pulse, .halt_line, .mains_failure(mfail), .system_reset_request(sysreq),
    .restart_done(rdone), .ctx, .evt, .blk_call(bcall), .blk_return(1'b0), .irq_enter(ienter),
    .irq_exit(1'b0), .periodic_done(pdone), .main_cycle_run(mrun), .fallback_cycle_run(frun),
    .periodic_request(preq), .stop_state(stop), .stop_handler_call(hcall),
    .output_disable_signal(odis), .overall_reset_required(ureq));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic complete_run;
    $display("compares %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rdv = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 50) begin
      bad_count++;
      complete_run();
    end
  endtask : apb
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdv, exp);
  endtask : rdc
  task automatic clr;
    apb(1'b1, pfsc_pkg::OFF_CTRL, 32'h1);
  endtask : clr
  task automatic rst;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
  endtask : rst
  task automatic ev(input pfsc_pkg::pfsc_evt_t x);
    @(posedge pclk);
    evt <= x;
    @(posedge pclk);
    evt <= '0;
  endtask : ev
  // Event, then fault word, stop and handler state, then clear
  task automatic evf(input pfsc_pkg::pfsc_evt_t x, input logic [31:0] f, input logic h);
    ev(x);
    rdc(pfsc_pkg::OFF_FAULT, f);
    chk(32'({stop, odis, hcall}), 32'({f != 0, f != 0, h}));
    clr();
  endtask : evf
  // Back-to-back block calls or interrupt entries
  task automatic calls(input logic irq, input int k);
    bcall <= !irq;
    ienter <= irq;
    repeat (k) @(posedge pclk);
    bcall <= 1'b0;
    ienter <= 1'b0;
  endtask : calls

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    rst();
    #1 chk(32'({mrun, frun}), 32'h2);
    @(posedge pclk);
    mload <= 1'b0;
    #1 chk(32'({mrun, frun}), 32'h1);
    for (int m = 0; m < 4; m++) begin
      @(posedge pclk);
      mem <= pfsc_pkg::pfsc_mem_t'(m);
      apb(1'b0, pfsc_pkg::OFF_STATUS, 32'h0);
      chk((rdv >> 4) & 32'hF, 32'h1 << m);
    end
    rdc(8'h40, 32'h0);
    chk(32'(perr), 32'h0);
    halt_req <= 1'b1;
    apb(1'b0, pfsc_pkg::OFF_STATUS, 32'h0);
    chk(32'({stop, rdv[pfsc_pkg::ST_HALT]}), 32'h3);
    halt_req <= 1'b0;
    apb(1'b1, pfsc_pkg::OFF_CTRL, 32'hE);
    sysreq <= 1'b1;
    mfail <= 1'b1;
    apb(1'b0, pfsc_pkg::OFF_STATUS, 32'h0);
    chk(rdv & 32'h3E00, 32'h3E00);
    chk(32'(ureq), 32'h1);
    sysreq <= 1'b0;
    mfail <= 1'b0;
    rdone <= 1'b1;
    apb(1'b0, pfsc_pkg::OFF_STATUS, 32'h0);
    chk(rdv & 32'h3E00, 32'h1E00);
    rdone <= 1'b0;
    rst();
    // Context frozen at an error stop while the live context moves on
    ctx <= '{cmd_word: 16'hA5C3, step_addr: 16'h1234, blk_start: 16'h1200, blk_id: 16'h0301,
             db_base: 16'h4000, jump_addr: 16'h0ABC, caller_id: 16'h0102, default: '0};
    rdc(pfsc_pkg::OFF_DB_BASE, 32'h7FFF);
    ctx.db_valid <= 1'b1;
    rdc(pfsc_pkg::OFF_DB_BASE, 32'h4000);
    e = '0;
    e.illegal_op = 1'b1;
    ev(e);
    ctx <= '0;
    #1 chk(32'({stop, hcall, odis}), 32'h7);
    e = '0;
    e.ack_miss = 1'b1;
    ev(e);
    rdc(pfsc_pkg::OFF_FAULT, 32'h8);
    rdc(pfsc_pkg::OFF_CMD_WORD, 32'hA5C3);
    rdc(pfsc_pkg::OFF_STEP_ADDR, 32'h1234);
    rdc(pfsc_pkg::OFF_REL_STEP, 32'h0034);
    rdc(pfsc_pkg::OFF_BLK_ID, 32'h0301);
    rdc(pfsc_pkg::OFF_CALLER_RET, 32'h0ABC);
    rdc(pfsc_pkg::OFF_CALLER_ID, 32'h0102);
    clr();
    evf(e, 32'h1, 1'b1);
    e = '0;
    e.img_addr_bad = 1'b1;
    evf(e, 32'h4, 1'b1);
    e = '0;
    e.unloaded_call = 1'b1;
    evf(e, 32'h8, 1'b1);
    e = '0;
    e.timer_access = 1'b1;
    e.timer_num = 16'h007F;
    evf(e, 32'h0, 1'b0);
    e.timer_num = 16'h0080;
    evf(e, 32'h8, 1'b1);
    e = '0;
    e.subst_bad = 1'b1;
    evf(e, 32'h10, 1'b1);
    e = '0;
    e.sf_missing = 1'b1;
    evf(e, 32'h60, 1'b1);
    e = '0;
    e.sf_runtime = 1'b1;
    evf(e, 32'hA0, 1'b1);
    e = '0;
    e.io_cfg_missing = 1'b1;
    evf(e, 32'h1000, 1'b0);
    e = '0;
    e.io_cfg_noack = 1'b1;
    evf(e, 32'h1000, 1'b0);
    // Every image area, then the vector falls back to the step address
    ctx.step_addr <= 16'h0777;
    e = '0;
    e.img_ack_miss = 1'b1;
    e.img_entry = 8'h05;
    for (int a = 0; a < 4; a++) begin
      e.img_area = pfsc_pkg::pfsc_area_t'(a);
      ev(e);
      rdc(pfsc_pkg::OFF_FAULT, 32'h2);
      rdc(pfsc_pkg::OFF_VEC_ADDR, 32'(vb[a] + 16'h0005));
      clr();
    end
    rdc(pfsc_pkg::OFF_VEC_ADDR, 32'h0777);
    // Periodic requests only when loaded; a second one while busy overruns
    for (n = 0; n < 120 && preq !== 1'b1; n++) @(posedge pclk);
    chk(32'(preq), 32'h0);
    pload <= 1'b1;
    for (n = 0; n < 200 && preq !== 1'b1; n++) @(posedge pclk);
    chk(32'(preq), 32'h1);
    if (preq !== 1'b1) complete_run();
    pdone <= 1'b1;
    @(posedge pclk);
    pdone <= 1'b0;
    @(posedge pclk);
    #1 chk(32'(preq), 32'h0);
    for (n = 0; n < 200 && preq !== 1'b1; n++) @(posedge pclk);
    chk(32'(preq), 32'h1);
    if (preq !== 1'b1) complete_run();
    repeat (60) @(posedge pclk);
    rdc(pfsc_pkg::OFF_FAULT, 32'h300);
    pload <= 1'b0;
    rst();
    clk_fail <= 1'b1;
    repeat (20) @(posedge pclk);
    rdc(pfsc_pkg::OFF_FAULT, 32'h100);
    clk_fail <= 1'b0;
    rst();
    // Depth limits: last legal level, then one beyond
    calls(1'b0, 24);
    rdc(pfsc_pkg::OFF_BLK_SP, 32'h18);
    rdc(pfsc_pkg::OFF_FAULT, 32'h0);
    calls(1'b0, 1);
    rdc(pfsc_pkg::OFF_FAULT, 32'h400);
    chk(32'({stop, hcall}), 32'h2);
    rst();
    calls(1'b1, 8);
    rdc(pfsc_pkg::OFF_IRQ_LEVEL, 32'h8);
    rdc(pfsc_pkg::OFF_FAULT, 32'h0);
    calls(1'b1, 1);
    rdc(pfsc_pkg::OFF_FAULT, 32'h800);
    complete_run();
  end
endmodule : plc_fault_status_capture_tb

/* rtl/pfsc_fault_capture.sv */
// Fault detection, status flags and context capture for the controller processor
`timescale 1ns/10ps
module pfsc_fault_capture #(
  parameter int PERIOD_CYCLES = pfsc_pkg::PERIOD_CYC,
  parameter int IRQ_DEPTH = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Processor status inputs
  input wire logic main_cycle_block_loaded,
  input wire logic fallback_cycle_block_loaded,
  input wire logic periodic_block_loaded,
  input wire pfsc_pkg::pfsc_mem_t mem_type,
  input wire logic cpu_clk_pulse,
  input wire logic halt_line,
  input wire logic mains_failure,
  input wire logic system_reset_request,
  input wire logic restart_done,
  // Processor context and events
  input wire pfsc_pkg::pfsc_ctx_t ctx,
  input wire pfsc_pkg::pfsc_evt_t evt,
  input wire logic blk_call,
  input wire logic blk_return,
  input wire logic irq_enter,
  input wire logic irq_exit,
  input wire logic periodic_done,
  // Outputs to the processor
  output logic main_cycle_run,
  output logic fallback_cycle_run,
  output logic periodic_request,
  output logic stop_state,
  output logic stop_handler_call,
  output logic output_disable_signal,
  output logic overall_reset_required
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [pfsc_pkg::NFAULT-1:0] fault;
    logic stop;
    logic handler;
    logic out_dis;
    logic first_ua;
    logic sys_ua;
    logic cold_ok;
    logic warm_ok;
    logic auto_warm;
    logic periodic_active;
    // Interval divider and clock pulse watchdog
    logic [31:0] period_cnt;
    logic [4:0] clk_watch;
    logic clk_prev;
    logic [5:0] blk_depth;
    logic [15:0] irq_level;
    logic [15:0] vec_addr;
    logic vec_img;
    // Context as it stood when stop was entered
    pfsc_pkg::pfsc_ctx_t snap;
    logic [31:0] rdata;
  } pfsc_state_t;

  pfsc_state_t s_r;
  pfsc_state_t s_nxt;

  // Area base plus entry gives the failing address
  function automatic logic [15:0] area_addr(input pfsc_pkg::pfsc_area_t a, input logic [7:0] e);
    logic [15:0] b;
    b = pfsc_pkg::VEC_IN_BASE;
    case (a)
      pfsc_pkg::PFSC_AREA_IN: b = pfsc_pkg::VEC_IN_BASE + {9'h000, e[6:0]};
      pfsc_pkg::PFSC_AREA_OUT: b = pfsc_pkg::VEC_OUT_BASE + {9'h000, e[6:0]};
      pfsc_pkg::PFSC_AREA_FIN: b = pfsc_pkg::VEC_FIN_BASE + {8'h00, e};
      pfsc_pkg::PFSC_AREA_FOUT: b = pfsc_pkg::VEC_FOUT_BASE + {8'h00, e};
      default: b = pfsc_pkg::VEC_IN_BASE;
    endcase
    return b;
  endfunction : area_addr

  // ------------------------------------------------------------
  // Combinational decode
  // ------------------------------------------------------------
  logic wr_acc;
  logic rd_setup;
  logic period_tick;
  logic [pfsc_pkg::NFAULT-1:0] ev;
  logic stop_err;
  logic [15:0] status_w;

  // Writes act in the access phase, reads are decoded at setup
  assign wr_acc = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  // One tick per periodic interval
  assign period_tick = (s_r.period_cnt == 32'(PERIOD_CYCLES - 1));

  // Raw fault events this cycle
  always_comb begin
    ev = '0;
    ev[pfsc_pkg::F_ACK_TIMEOUT] = evt.ack_miss;
    ev[pfsc_pkg::F_IMG_TIMEOUT] = evt.img_ack_miss;
    ev[pfsc_pkg::F_IMG_ADDR] = evt.img_addr_bad;
    ev[pfsc_pkg::F_OPCODE] = evt.illegal_op || evt.unloaded_call ||
      (evt.timer_access && (evt.timer_masked || evt.timer_num > 16'(pfsc_pkg::TIMER_MAX)));
    ev[pfsc_pkg::F_SUBST] = evt.subst_bad;
    ev[pfsc_pkg::F_SF_MISSING] = evt.sf_missing;
    ev[pfsc_pkg::F_SF_RUNTIME] = evt.sf_runtime;
    ev[pfsc_pkg::F_PERIODIC_OVR] = period_tick && s_r.periodic_active && periodic_block_loaded;
    ev[pfsc_pkg::F_TIMING] = ev[pfsc_pkg::F_PERIODIC_OVR] ||
      (s_r.clk_watch == 5'(pfsc_pkg::CLK_WATCH_CYC));
    ev[pfsc_pkg::F_BLK_NEST] = blk_call && (s_r.blk_depth == 6'(pfsc_pkg::BLK_NEST_MAX));
    ev[pfsc_pkg::F_IRQ_NEST] = irq_enter && (s_r.irq_level == 16'(IRQ_DEPTH));
    ev[pfsc_pkg::F_IO_LIST] = evt.io_cfg_missing || evt.io_cfg_noack;
    ev[pfsc_pkg::F_SF_GROUP] = ev[pfsc_pkg::F_SF_MISSING] || ev[pfsc_pkg::F_SF_RUNTIME];
  end

  // Errors that stop with the handler; overflows and io list stop without it
  localparam logic [pfsc_pkg::NFAULT-1:0] NO_HANDLER_M = pfsc_pkg::NFAULT'((1 << pfsc_pkg::F_BLK_NEST) |
    (1 << pfsc_pkg::F_IRQ_NEST) | (1 << pfsc_pkg::F_IO_LIST));
  assign stop_err = |(ev & ~NO_HANDLER_M);

  // Status word as read by software
  always_comb begin
    status_w = '0;
    status_w[pfsc_pkg::ST_STOP] = s_r.stop;
    status_w[pfsc_pkg::ST_MAIN_RUN] = main_cycle_run;
    status_w[pfsc_pkg::ST_FALLBACK_RUN] = fallback_cycle_run;
    status_w[pfsc_pkg::ST_PERIODIC_LOADED] = periodic_block_loaded;
    status_w[pfsc_pkg::ST_RAM32] = (mem_type == pfsc_pkg::PFSC_MEM_RAM32);
    status_w[pfsc_pkg::ST_RAM16] = (mem_type == pfsc_pkg::PFSC_MEM_RAM16);
    status_w[pfsc_pkg::ST_RAM8] = (mem_type == pfsc_pkg::PFSC_MEM_RAM8);
    status_w[pfsc_pkg::ST_EPROM] = (mem_type == pfsc_pkg::PFSC_MEM_EPROM);
    status_w[pfsc_pkg::ST_HALT] = halt_line;
    status_w[pfsc_pkg::ST_FIRST_UA] = s_r.first_ua;
    status_w[pfsc_pkg::ST_SYS_UA] = s_r.sys_ua;
    status_w[pfsc_pkg::ST_COLD_OK] = s_r.cold_ok;
    status_w[pfsc_pkg::ST_WARM_OK] = s_r.warm_ok;
    status_w[pfsc_pkg::ST_AUTO_WARM] = s_r.auto_warm;
    status_w[pfsc_pkg::ST_OUT_DISABLE] = s_r.out_dis;
    status_w[pfsc_pkg::ST_STOP_HANDLER] = s_r.handler;
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    // Periodic interval divider
    s_nxt.period_cnt = period_tick ? '0 : s_r.period_cnt + 32'h1;
    if (periodic_done) begin
      s_nxt.periodic_active = 1'b0;
    end
    // A tick while stopped starts nothing
    if (period_tick && periodic_block_loaded && !s_r.stop) begin
      s_nxt.periodic_active = 1'b1;
    end

    // Clock pulse watchdog counts cycles without a pulse edge
    s_nxt.clk_prev = cpu_clk_pulse;
    if (cpu_clk_pulse != s_r.clk_prev) begin
      s_nxt.clk_watch = '0;
    end else if (s_r.clk_watch != 5'(pfsc_pkg::CLK_WATCH_CYC)) begin
      s_nxt.clk_watch = s_r.clk_watch + 5'h1;
    end

    // Stack tracking frozen while stopped
    if (!s_r.stop) begin
      // Block call depth, saturating at the limit
      if (blk_call && !blk_return && s_r.blk_depth != 6'(pfsc_pkg::BLK_NEST_MAX)) begin
        s_nxt.blk_depth = s_r.blk_depth + 6'h1;
      end else if (blk_return && !blk_call && s_r.blk_depth != '0) begin
        s_nxt.blk_depth = s_r.blk_depth - 6'h1;
      end
      // Interrupt stack level orders nested entries
      if (irq_enter && !irq_exit && s_r.irq_level != 16'(IRQ_DEPTH)) begin
        s_nxt.irq_level = s_r.irq_level + 16'h1;
      end else if (irq_exit && !irq_enter && s_r.irq_level != '0) begin
        s_nxt.irq_level = s_r.irq_level - 16'h1;
      end
      // Live context, held once stop is entered
      s_nxt.snap = ctx;
      s_nxt.fault = s_r.fault | ev;
      // Vector keeps the failing area until clear
      if (evt.img_ack_miss) begin
        s_nxt.vec_addr = area_addr(evt.img_area, evt.img_entry);
        s_nxt.vec_img = 1'b1;
      end else if (!s_r.vec_img) begin
        s_nxt.vec_addr = ctx.step_addr;
      end
      if (|ev) begin
        s_nxt.stop = 1'b1;
        s_nxt.out_dis = 1'b1;
        s_nxt.handler = stop_err;
      end
    end

    // Reset requests and restart permissions
    if (system_reset_request) begin
      s_nxt.sys_ua = 1'b1;
    end
    // Restart done clears first so a power failure in the same cycle is kept
    if (restart_done) begin
      s_nxt.auto_warm = 1'b0;
    end
    if (mains_failure) begin
      s_nxt.auto_warm = 1'b1;
    end

    // Software writes; hardware sets above win over clears, except a periodic start, which a clear cancels
    if (wr_acc && paddr == pfsc_pkg::OFF_CTRL) begin
      s_nxt.cold_ok = pwdata[pfsc_pkg::CTRL_COLD_OK];
      s_nxt.warm_ok = pwdata[pfsc_pkg::CTRL_WARM_OK];
      if (pwdata[pfsc_pkg::CTRL_FIRST_UA]) begin
        s_nxt.first_ua = 1'b1;
      end
      if (pwdata[pfsc_pkg::CTRL_CLEAR] && !(|ev)) begin
        s_nxt.fault = '0;
        s_nxt.stop = 1'b0;
        s_nxt.handler = 1'b0;
        s_nxt.out_dis = 1'b0;
        s_nxt.vec_img = 1'b0;
        s_nxt.blk_depth = '0;
        s_nxt.irq_level = '0;
        s_nxt.first_ua = 1'b0;
        s_nxt.sys_ua = system_reset_request;
        s_nxt.periodic_active = 1'b0;
      end
    end

    // Read data captured at setup so the access phase answers at once
    if (rd_setup) begin
      case (paddr)
        pfsc_pkg::OFF_STATUS: s_nxt.rdata = {16'h0000, status_w};
        pfsc_pkg::OFF_FAULT: s_nxt.rdata = {19'h00000, s_r.fault};
        pfsc_pkg::OFF_CTRL: s_nxt.rdata = {28'h0000000, s_r.warm_ok, s_r.cold_ok, s_r.first_ua, 1'b0};
        pfsc_pkg::OFF_IRQ_LEVEL: s_nxt.rdata = {16'h0000, s_r.irq_level};
        pfsc_pkg::OFF_CMD_WORD: s_nxt.rdata = {16'h0000, s_r.snap.cmd_word};
        pfsc_pkg::OFF_BLK_SP: s_nxt.rdata = {26'h0000000, s_r.blk_depth};
        pfsc_pkg::OFF_VEC_ADDR: s_nxt.rdata = {16'h0000, s_r.vec_addr};
        pfsc_pkg::OFF_STEP_ADDR: s_nxt.rdata = {16'h0000, s_r.snap.step_addr};
        pfsc_pkg::OFF_BLK_ID: s_nxt.rdata = {16'h0000, s_r.snap.blk_id};
        pfsc_pkg::OFF_REL_STEP: s_nxt.rdata = {16'h0000, 16'(s_r.snap.step_addr - s_r.snap.blk_start)};
        pfsc_pkg::OFF_IRQ_MASK: s_nxt.rdata = {16'h0000, s_r.snap.irq_mask};
        pfsc_pkg::OFF_IRQ_ERASE: s_nxt.rdata = {16'h0000, s_r.snap.irq_erase};
        pfsc_pkg::OFF_DB_BASE:
          s_nxt.rdata = {16'h0000, s_r.snap.db_valid ? s_r.snap.db_base : pfsc_pkg::DB_NONE};
        pfsc_pkg::OFF_CALLER_RET: s_nxt.rdata = {16'h0000, s_r.snap.jump_addr};
        pfsc_pkg::OFF_CALLER_ID: s_nxt.rdata = {16'h0000, s_r.snap.caller_id};
        pfsc_pkg::OFF_ACCU: s_nxt.rdata = s_r.snap.accu;
        default: s_nxt.rdata = '0;
      endcase
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Zero wait states and no error response
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = s_r.rdata;
  // Main block always wins so the two never both run
  assign main_cycle_run = main_cycle_block_loaded && !s_r.stop;
  assign fallback_cycle_run = fallback_cycle_block_loaded && !main_cycle_block_loaded && !s_r.stop;
  assign periodic_request = s_r.periodic_active;
  assign stop_state = s_r.stop || halt_line;
  assign stop_handler_call = s_r.handler;
  assign output_disable_signal = s_r.out_dis;
  assign overall_reset_required = s_r.sys_ua;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  run_exclusive_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(main_cycle_run && fallback_cycle_run)) else $error("both cycle blocks run");

  periodic_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(periodic_request) |-> $past(periodic_block_loaded)) else $error("periodic without block");

  overrun_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ev[pfsc_pkg::F_PERIODIC_OVR] && !s_r.stop) |=> (s_r.fault[pfsc_pkg::F_TIMING] && s_r.stop))
    else $error("overrun not flagged");

  clk_fail_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_r.clk_watch == 5'(pfsc_pkg::CLK_WATCH_CYC) && !s_r.stop) |=> (s_r.fault[pfsc_pkg::F_TIMING] && s_r.stop))
    else $error("clock failure missed");

  nest_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (blk_call && s_r.blk_depth == 6'(pfsc_pkg::BLK_NEST_MAX) && !s_r.stop) |=> s_r.fault[pfsc_pkg::F_BLK_NEST])
    else $error("nest overflow missed");

  irq_nest_a: assert property (@(posedge pclk) disable iff (!presetn)
    (irq_enter && s_r.irq_level == 16'(IRQ_DEPTH) && !s_r.stop) |=> s_r.fault[pfsc_pkg::F_IRQ_NEST])
    else $error("interrupt overflow missed");

  sf_group_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_r.fault[pfsc_pkg::F_SF_GROUP] == (s_r.fault[pfsc_pkg::F_SF_MISSING] || s_r.fault[pfsc_pkg::F_SF_RUNTIME]))
    else $error("group fault mismatch");

  vec_area_a: assert property (@(posedge pclk) disable iff (!presetn)
    (evt.img_ack_miss && evt.img_area == pfsc_pkg::PFSC_AREA_OUT && !s_r.stop) |=>
    (s_r.vec_addr[15:7] == 9'h1C5)) else $error("vector area wrong");

  reset_req_a: assert property (@(posedge pclk) disable iff (!presetn)
    system_reset_request |=> overall_reset_required)
    else $error("reset request missed");

  warm_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    mains_failure |=> s_r.auto_warm)
    else $error("warm restart flag missed");

  stop_outdis_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(s_r.stop) |-> output_disable_signal) else $error("no output disable");

  handler_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!s_r.stop && ev == (1 << pfsc_pkg::F_IO_LIST)) |=> (s_r.stop && !stop_handler_call))
    else $error("handler on io list fault");

  stop_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_r.stop && !wr_acc) |=> (s_r.stop && $stable(s_r.fault)))
    else $error("stop or faults changed");

  frozen_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_r.stop && $past(s_r.stop) && !$past(wr_acc)) |-> $stable(s_r.snap) && $stable(s_r.irq_level))
    else $error("capture changed in stop");

endmodule : pfsc_fault_capture

/* rtl/pfsc_pkg.sv */
// Package: register map, field layout and timing constants of the fault status capture block
package pfsc_pkg;

  // ------------------------------------------------------------
  // Register byte offsets (APB, one aligned word each)
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_FAULT = 8'h08;
  localparam logic [7:0] OFF_IRQ_LEVEL = 8'h0C;
  localparam logic [7:0] OFF_CMD_WORD = 8'h10;
  localparam logic [7:0] OFF_BLK_SP = 8'h14;
  localparam logic [7:0] OFF_VEC_ADDR = 8'h18;
  localparam logic [7:0] OFF_STEP_ADDR = 8'h1C;
  localparam logic [7:0] OFF_BLK_ID = 8'h20;
  localparam logic [7:0] OFF_REL_STEP = 8'h24;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h28;
  localparam logic [7:0] OFF_IRQ_ERASE = 8'h2C;
  localparam logic [7:0] OFF_DB_BASE = 8'h30;
  localparam logic [7:0] OFF_CALLER_RET = 8'h34;
  localparam logic [7:0] OFF_CALLER_ID = 8'h38;
  localparam logic [7:0] OFF_ACCU = 8'h3C;

  // ------------------------------------------------------------
  // Control register fields
  // ------------------------------------------------------------
  localparam int CTRL_CLEAR = 0;    // Write 1: clear faults and leave stop
  localparam int CTRL_FIRST_UA = 1; // Write 1: first overall reset request
  localparam int CTRL_COLD_OK = 2;
  localparam int CTRL_WARM_OK = 3;

  // ------------------------------------------------------------
  // Status register fields
  // ------------------------------------------------------------
  localparam int ST_STOP = 0;
  localparam int ST_MAIN_RUN = 1;
  localparam int ST_FALLBACK_RUN = 2;
  localparam int ST_PERIODIC_LOADED = 3;
  localparam int ST_RAM32 = 4;
  localparam int ST_RAM16 = 5;
  localparam int ST_RAM8 = 6;
  localparam int ST_EPROM = 7;
  localparam int ST_HALT = 8;
  localparam int ST_FIRST_UA = 9;
  localparam int ST_SYS_UA = 10;
  localparam int ST_COLD_OK = 11;
  localparam int ST_WARM_OK = 12;
  localparam int ST_AUTO_WARM = 13;
  localparam int ST_OUT_DISABLE = 14;
  localparam int ST_STOP_HANDLER = 15;

  // ------------------------------------------------------------
  // Fault register fields (index into fault vector)
  // ------------------------------------------------------------
  localparam int NFAULT = 13;
  localparam int F_ACK_TIMEOUT = 0;
  localparam int F_IMG_TIMEOUT = 1;
  localparam int F_IMG_ADDR = 2;
  localparam int F_OPCODE = 3;
  localparam int F_SUBST = 4;
  localparam int F_SF_GROUP = 5;
  localparam int F_SF_MISSING = 6;
  localparam int F_SF_RUNTIME = 7;
  localparam int F_TIMING = 8;
  localparam int F_PERIODIC_OVR = 9;
  localparam int F_BLK_NEST = 10;
  localparam int F_IRQ_NEST = 11;
  localparam int F_IO_LIST = 12;

  // ------------------------------------------------------------
  // Fixed values
  // ------------------------------------------------------------
  localparam logic [15:0] DB_NONE = 16'h7FFF;
  localparam logic [15:0] VEC_IN_BASE = 16'hE200;
  localparam logic [15:0] VEC_OUT_BASE = 16'hE280;
  localparam logic [15:0] VEC_FIN_BASE = 16'hE300;
  localparam logic [15:0] VEC_FOUT_BASE = 16'hE400;
  localparam int BLK_NEST_MAX = 24;
  localparam int TIMER_MAX = 127;
  localparam int CLK_MHZ = 200;
  localparam int PERIOD_MS = 100;
  localparam int PERIOD_CYC = PERIOD_MS * 1000 * CLK_MHZ;
  localparam int CLK_WATCH_CYC = 16;

  // Image update areas
  typedef enum logic [1:0] {
    PFSC_AREA_IN,
    PFSC_AREA_OUT,
    PFSC_AREA_FIN,
    PFSC_AREA_FOUT
  } pfsc_area_t;

  // Memory module type
  typedef enum logic [1:0] {
    PFSC_MEM_RAM32,
    PFSC_MEM_RAM16,
    PFSC_MEM_RAM8,
    PFSC_MEM_EPROM
  } pfsc_mem_t;

  // Processor context snapshot
  typedef struct packed {
    logic [15:0] cmd_word;
    logic [15:0] step_addr;
    logic [15:0] blk_start;
    logic [15:0] blk_id;
    logic [15:0] db_base;
    logic db_valid;
    logic [15:0] jump_addr;
    logic [15:0] caller_id;
    logic [15:0] irq_mask;
    logic [15:0] irq_erase;
    logic [31:0] accu;
  } pfsc_ctx_t;

  // Error event strobes from the execution unit
  typedef struct packed {
    logic ack_miss;
    logic img_ack_miss;
    pfsc_area_t img_area;
    logic [7:0] img_entry;
    logic img_addr_bad;
    logic illegal_op;
    logic unloaded_call;
    logic timer_masked;
    logic [15:0] timer_num;
    logic timer_access;
    logic subst_bad;
    logic sf_missing;
    logic sf_runtime;
    logic io_cfg_missing;
    logic io_cfg_noack;
  } pfsc_evt_t;

endpackage : pfsc_pkg
